// File: file_access.v
// transparent and record file access engine with its register port
// assumes software loads p1, p2, length, then writes the command register
//
// Summary of operation
// RL1 - transparent read only when read allowed
// RL2 - p1 b8 zero: fifteen bit offset
// RL3 - p1 100: short identifier, p2 offset
// RL4 - read returns exactly the expected length
// RL5 - transparent write only when update allowed
// RL6 - write shares read parameter coding
// RL7 - failed record read keeps pointer
// RL8 - current and absolute keep pointer
// RL9 - next increments pointer, unset reads first
// RL10 - linear end of file: no data, pointer kept
// RL11 - cyclic next at last wraps first
// RL12 - previous decrements pointer, unset reads last
// RL13 - cyclic previous at first wraps last
// RL14 - p2 high bits choose file
// RL15 - p2 low bits choose record mode
// RL16 - terminal puts zero p1 for next/previous
// RL17 - record update needs update access, keeps pointer
// RL18 - cyclic files accept only previous updates
// RL19 - linear next update, stop at last
// RL20 - linear previous update, stop at first
// RL21 - cyclic previous update renumbers oldest record
// RL22 - update shares record mode coding
// RL23 - unlisted parameter codes are rejected cleanly
`timescale 1ns/1ps
`include "file_access_map.vh"
module file_access #(
    parameter NF = 4,
    parameter FW = 2,
    parameter AW = 8
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // engine state
    output wire        busy
);
    localparam S_IDLE  = 2'h0;
    localparam S_CHECK = 2'h1;
    localparam S_XFER  = 2'h2;

    reg  [1:0]    state;
    reg  [1:0]    cmd;
    reg  [7:0]    p1;
    reg  [7:0]    p2;
    reg  [7:0]    len;
    reg  [FW-1:0] sel;
    reg  [FW-1:0] cfgSel;
    reg  [31:0]   cfgWord  [0:NF-1];
    reg  [31:0]   geomWord [0:NF-1];
    reg  [7:0]    head     [0:NF-1];
    reg  [7:0]    ptr;
    reg           ptrSet;
    reg  [2:0]    result;
    reg  [7:0]    count;
    reg  [AW-1:0] xAddr;
    wire [7:0]    memRd;
    wire          memWe;
    integer       i;
    integer       j;

    // check-stage results
    reg  [2:0]    chkErr;
    reg  [FW-1:0] tgt;
    reg           found;
    reg  [4:0]    short_file_identifier;
    reg  [14:0]   ofs;
    reg  [7:0]    lrec;
    reg  [7:0]    prec;
    reg  [7:0]    next_ptr;
    reg           next_ptrSet;
    reg           moveHead;
    reg  [AW-1:0] startAddr;
    reg           ptrEff;
    reg  [1:0]    fType;
    reg  [7:0]    nrec;
    reg  [7:0]    rlen;
    reg  [7:0]    base;

    assign busy = (state != S_IDLE);

    // logical record to physical slot; head marks record one
    function [7:0] wrapRec;
        input [7:0] hd;
        input [7:0] lr;
        input [7:0] nr;
        reg   [8:0] s;
        begin
            s = {1'b0, hd} + {1'b0, lr} - 9'h001;
            if (s >= {1'b0, nr}) begin
                s = s - {1'b0, nr};
            end
            wrapRec = s[7:0];
        end
    endfunction

    function [AW-1:0] recAddr;
        input [7:0] bs;
        input [7:0] slot;
        input [7:0] rl;
        reg   [15:0] a;
        begin
            a = {8'h00, bs} + slot * rl;
            recAddr = a[AW-1:0];
        end
    endfunction

    always @* begin
        chkErr      = `RES_OK;
        tgt         = sel;
        found       = 1'b0;
        short_file_identifier         = `SFI_CURRENT;
        ofs         = 15'h0000;
        lrec        = `REC_FIRST;
        prec        = 8'h00;
        next_ptr    = ptr;
        next_ptrSet = ptrSet;
        moveHead    = 1'b0;
        startAddr   = {AW{1'b0}};
        i           = 0;
        // resolve the file reference
        if (!cmd[1]) begin
            if (!p1[`P1_SFI_FLAG]) begin
                ofs = {p1[`P1_OFS_HI], p2};                          // [RL2] [RL6]
            end else if (p1[`P1_SFI_PAD] == 2'b00) begin
                short_file_identifier = p1[`P1_SFI];                                   // [RL3] [RL6]
                ofs = {7'h00, p2};
            end else begin
                chkErr = `RES_PARAM;                                 // [RL23]
            end
        end else begin
            short_file_identifier = p2[`P2_SFI];                                       // [RL14] [RL22]
            if (short_file_identifier == `SFI_RFU) begin
                chkErr = `RES_PARAM;                                 // [RL23]
            end
        end
        if (short_file_identifier == `SFI_CURRENT) begin
            found = (cfgWord[sel][`CFG_TYPE] != `FT_NONE);
        end else begin
            for (i = 0; i < NF; i = i + 1) begin
                if (!found && cfgWord[i][`CFG_TYPE] != `FT_NONE && cfgWord[i][`CFG_SFI] == short_file_identifier) begin
                    found = 1'b1;
                    tgt   = i[FW-1:0];
                end
            end
        end
        fType  = cfgWord[tgt][`CFG_TYPE];
        nrec   = geomWord[tgt][`GEOM_NREC];
        rlen   = geomWord[tgt][`GEOM_RLEN];
        base   = geomWord[tgt][`GEOM_BASE];
        // a newly selected file starts with no pointer
        ptrEff = ptrSet && (tgt == sel);
        if (!ptrEff) begin
            next_ptrSet = 1'b0;
        end
        if (chkErr != `RES_OK) begin
            chkErr = chkErr;
        end else if (!found) begin
            chkErr = `RES_NOFILE;
        end else if (cmd[1] ? (fType == `FT_TRANSP) : (fType != `FT_TRANSP)) begin
            chkErr = `RES_TYPE;
        end else if (cmd[0] ? !cfgWord[tgt][`CFG_UP_OK] : !cfgWord[tgt][`CFG_RD_OK]) begin
            chkErr = `RES_ACCESS;                                    // [RL1] [RL5] [RL17]
        end else if (!cmd[1]) begin
            // full sixteen bit file size, a 256 byte file must not wrap to zero
            if ({2'b00, ofs} + {9'h000, len} > {1'b0, {8'h00, nrec} * {8'h00, rlen}}) begin
                chkErr = `RES_RANGE;
            end
            startAddr = base + ofs[AW-1:0];
        end else if (len != rlen) begin
            chkErr = `RES_LENGTH;
        end else if (cmd[0] && fType == `FT_CYCLIC) begin
            if (p2[`P2_MODE] != `MODE_PREV) begin
                chkErr = `RES_TYPE;                                  // [RL18]
            end else begin
                // oldest data sits in the slot before record one
                prec        = wrapRec(head[tgt], nrec, nrec);        // [RL21]
                moveHead    = 1'b1;
                next_ptr    = `REC_FIRST;
                next_ptrSet = 1'b1;
            end
        end else begin
            case (p2[`P2_MODE])                                      // [RL15] [RL22]
                `MODE_NEXT: begin
                    if (!ptrEff) begin
                        lrec = `REC_FIRST;                           // [RL9] [RL19]
                    end else if (ptr == nrec) begin
                        if (fType == `FT_LINEAR) begin
                            chkErr = `RES_RANGE;                     // [RL10] [RL19]
                        end else begin
                            lrec = `REC_FIRST;                       // [RL11]
                        end
                    end else begin
                        lrec = ptr + 8'h01;                          // [RL9]
                    end
                    next_ptr    = lrec;
                    next_ptrSet = 1'b1;
                end
                `MODE_PREV: begin
                    if (!ptrEff) begin
                        lrec = nrec;                                 // [RL12] [RL20]
                    end else if (ptr == `REC_FIRST) begin
                        if (fType == `FT_LINEAR) begin
                            chkErr = `RES_RANGE;                     // [RL10] [RL20]
                        end else begin
                            lrec = nrec;                             // [RL13]
                        end
                    end else begin
                        lrec = ptr - 8'h01;                          // [RL12]
                    end
                    next_ptr    = lrec;
                    next_ptrSet = 1'b1;
                end
                `MODE_ABS: begin
                    // p1 is ignored for next/previous, trusted zero there [RL16]
                    if (p1 == `REC_CURRENT) begin
                        if (!ptrEff) begin
                            chkErr = `RES_RANGE;
                        end
                        lrec = ptr;                                  // [RL8]
                    end else if (p1 > nrec) begin
                        chkErr = `RES_RANGE;
                    end else begin
                        lrec = p1;                                   // [RL8]
                    end
                end
                default: begin
                    chkErr = `RES_PARAM;                             // [RL23]
                end
            endcase
            if (nrec == 8'h00) begin
                chkErr = `RES_RANGE;
            end
            prec = (fType == `FT_CYCLIC) ? wrapRec(head[tgt], lrec, nrec) : (lrec - 8'h01);
        end
        if (cmd[1]) begin
            startAddr = recAddr(base, prec, rlen);
        end
    end

    assign memWe = (state == S_XFER) && wr && (addr == `REG_DATA) && cmd[0] && (count != 8'h00);

    file_store #(
        .AW    (AW)
    ) store (
        .mclk  (mclk),
        .we    (memWe),
        .waddr (xAddr),
        .wdata (wdata[7:0]),
        .raddr (xAddr),
        .rdata (memRd)
    );

    always @(posedge mclk) begin
        if (!rst_n) begin
            state  <= S_IDLE;
            cmd    <= `CMD_TREAD;
            p1     <= 8'h00;
            p2     <= 8'h00;
            len    <= 8'h00;
            sel    <= {FW{1'b0}};
            cfgSel <= {FW{1'b0}};
            ptr    <= 8'h00;
            ptrSet <= 1'b0;
            result <= `RES_OK;
            count  <= 8'h00;
            xAddr  <= {AW{1'b0}};
            rdata  <= 32'h00000000;
            for (j = 0; j < NF; j = j + 1) begin
                cfgWord[j]  <= `CFG_RESET;
                geomWord[j] <= `GEOM_RESET;
                head[j]     <= 8'h00;
            end
        end else begin
            rdata <= 32'h00000000;
            if (wr && state == S_IDLE) begin
                case (addr)
                    `REG_CMD: begin
                        cmd   <= wdata[`CMD_FIELD];
                        state <= S_CHECK;
                    end
                    `REG_P1:     p1 <= wdata[7:0];
                    `REG_P2:     p2 <= wdata[7:0];
                    `REG_LEN:    len <= wdata[7:0];
                    `REG_SELECT: begin
                        sel    <= wdata[FW-1:0];
                        ptrSet <= 1'b0;
                    end
                    `REG_CFGSEL: cfgSel <= wdata[FW-1:0];
                    `REG_CFG:    cfgWord[cfgSel] <= wdata;
                    `REG_GEOM: begin
                        geomWord[cfgSel] <= wdata;
                        head[cfgSel]     <= 8'h00;
                    end
                    default: begin
                    end
                endcase
            end
            if (rd) begin
                case (addr)
                    `REG_P1:     rdata <= {24'h000000, p1};
                    `REG_P2:     rdata <= {24'h000000, p2};
                    `REG_LEN:    rdata <= {24'h000000, len};
                    `REG_SELECT: rdata <= {{(32-FW){1'b0}}, sel};
                    `REG_CFGSEL: rdata <= {{(32-FW){1'b0}}, cfgSel};
                    `REG_CFG:    rdata <= cfgWord[cfgSel];
                    `REG_GEOM:   rdata <= geomWord[cfgSel];
                    `REG_STATUS: begin
                        rdata[`ST_BUSY]    <= busy;
                        rdata[`ST_PTR_SET] <= ptrSet;
                        rdata[`ST_RESULT]  <= result;
                        rdata[`ST_SEL]     <= sel;
                        rdata[`ST_PTR]     <= ptr;
                    end
                    `REG_DATA: begin
                        if (state == S_XFER && !cmd[0] && count != 8'h00) begin
                            rdata <= {24'h000000, memRd};            // [RL4]
                        end
                    end
                    default: begin
                    end
                endcase
            end
            case (state)
                S_IDLE: begin
                end
                S_CHECK: begin
                    result <= chkErr;
                    // nothing but the result is committed unless every check passed [RL7] [RL17] [RL23]
                    if (chkErr == `RES_OK) begin
                        sel    <= tgt;
                        ptr    <= next_ptr;
                        ptrSet <= next_ptrSet;
                        if (moveHead) begin
                            head[tgt] <= prec;                       // [RL21]
                        end
                        xAddr <= startAddr;
                        count <= len;
                        state <= (len == 8'h00) ? S_IDLE : S_XFER;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_XFER: begin
                    // one byte moves per data access; the count ends the command [RL4]
                    if (addr == `REG_DATA && (cmd[0] ? wr : rd)) begin
                        xAddr <= xAddr + {{(AW-1){1'b0}}, 1'b1};
                        count <= count - 8'h01;
                        if (count == 8'h01) begin
                            state <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // file_access

// File: file_access_map.vh
// register offsets, field layouts and codes for the file access engine
// assumes a byte-addressed plain register port with word-aligned offsets
`ifndef FILE_ACCESS_MAP_VH
`define FILE_ACCESS_MAP_VH

// register byte offsets
`define REG_CMD        8'h00
`define REG_P1         8'h04
`define REG_P2         8'h08
`define REG_LEN        8'h0C
`define REG_DATA       8'h10
`define REG_STATUS     8'h14
`define REG_SELECT     8'h18
`define REG_CFGSEL     8'h1C
`define REG_CFG        8'h20
`define REG_GEOM       8'h24

// command codes written to the command register
`define CMD_FIELD      1:0
`define CMD_TREAD      2'h0
`define CMD_TWRITE     2'h1
`define CMD_RREAD      2'h2
`define CMD_RUPDATE    2'h3

// per-file configuration word
`define CFG_TYPE       1:0
`define CFG_RD_OK      2
`define CFG_UP_OK      3
`define CFG_SFI        8:4
`define CFG_RESET      32'h00000000
`define FT_NONE        2'h0
`define FT_TRANSP      2'h1
`define FT_LINEAR      2'h2
`define FT_CYCLIC      2'h3

// per-file geometry word: base address, record length, record count
`define GEOM_BASE      7:0
`define GEOM_RLEN      15:8
`define GEOM_NREC      23:16
`define GEOM_RESET     32'h00000000

// parameter byte fields
`define P1_SFI_FLAG    7
`define P1_SFI_PAD     6:5
`define P1_OFS_HI      6:0
`define P1_SFI         4:0
`define P2_SFI         7:3
`define P2_MODE        2:0
`define MODE_NEXT      3'h2
`define MODE_PREV      3'h3
`define MODE_ABS       3'h4
`define SFI_CURRENT    5'h00
`define SFI_RFU        5'h1F
`define REC_CURRENT    8'h00
`define REC_FIRST      8'h01

// status word
`define ST_BUSY        0
`define ST_PTR_SET     3
`define ST_RESULT      6:4
`define ST_SEL         9:8
`define ST_PTR         23:16

// result codes
`define RES_OK         3'h0
`define RES_ACCESS     3'h1
`define RES_PARAM      3'h2
`define RES_NOFILE     3'h3
`define RES_TYPE       3'h4
`define RES_RANGE      3'h5
`define RES_LENGTH     3'h6

`endif

// File: file_store.v
// byte-wide file memory shared by all files of the card
// assumes one writer; reads are combinational from the array
`timescale 1ns/1ps
module file_store #(
    parameter AW = 8
) (
    // clock
    input  wire          mclk,
    // write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [7:0]    wdata,
    // read port
    input  wire [AW-1:0] raddr,
    output wire [7:0]    rdata
);
    reg [7:0] mem [0:(1<<AW)-1];

    // no reset: contents persist like a card's non-volatile store
    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule // file_store

// File: file_access_properties.sv
// port-level checks for the file access engine
// assumes one clock domain; bound onto every file_access instance
`timescale 1ns/1ps
`include "file_access_map.vh"
module file_access_properties (
    // clock and reset
    input wire        mclk,
    input wire        rst_n,
    // register port
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    // engine state
    input wire        busy
);
    reg  [7:0] lenSeen;
    reg  [7:0] left;
    wire       cmdGo   = wr && !busy && addr == `REG_CMD;
    wire       dataHit = busy && (wr || rd) && addr == `REG_DATA;
    // shadow length and data accesses still owed by the transfer
    always @(posedge mclk) begin
        if (!rst_n) begin
            lenSeen <= 8'h00;
            left <= 8'h00;
        end else begin
            if (wr && !busy && addr == `REG_LEN) begin
                lenSeen <= wdata[7:0];
            end
            if (cmdGo) begin
                left <= lenSeen;
            end else if (dataHit && left != 8'h00) begin
                left <= left - 8'h01;
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_cmd_starts_check: assert property (cmdGo |=> busy)
        else $error("command write did not start the engine");
    a_idle_until_cmd: assert property (!busy && !cmdGo |=> !busy)
        else $error("engine left idle without a command");
    a_check_then_done: assert property (busy && left == 8'h00 |-> $past(cmdGo))
        else $error("engine busy with no data access owed");
    a_xfer_stops_exact: assert property (dataHit && left == 8'h01 |=> !busy)
        else $error("engine still busy after the last data byte");
    a_rdata_quiet: assert property (!rd |=> rdata == 32'h00000000)
        else $error("read data present without a read");
    a_data_idle_zero: assert property (rd && !busy && addr == `REG_DATA |=> rdata == 32'h00000000)
        else $error("data returned outside a read transfer");
    a_unmapped_zero: assert property (rd && addr > `REG_GEOM |=> rdata == 32'h00000000)
        else $error("unmapped address returned data");
    a_status_busy_bit: assert property (rd && addr == `REG_STATUS |=> rdata[0] == $past(busy))
        else $error("status busy bit disagrees with engine");
endmodule // file_access_properties
bind file_access file_access_properties u_props (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));

// File: terminal_model.sv
// terminal side of the register port: bus cycles and command framing
// assumes the engine takes one strobe per rising edge and never waits
`timescale 1ns/1ps
`include "file_access_map.vh"
module terminal_model (
    // clock
    input  wire        mclk,
    // register port
    output reg  [7:0]  addr,
    output reg  [31:0] wdata,
    output reg         wr,
    output reg         rd
);
    initial begin
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task wreg(input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            rd <= 1'b0;
        end
    endtask
    // write data flips while unused so stale values never look valid
    task rreg(input [7:0] a);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= ~wdata;
            wr <= 1'b0;
            rd <= 1'b1;
        end
    endtask
    task idle;
        begin
            @(posedge mclk);
            wdata <= ~wdata;
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task issue(input [1:0] c, input [7:0] p1, input [7:0] p2, input [7:0] ln);
        reg [7:0] p1Eff;
        begin
            p1Eff = p1;
            if (c[1] && (p2[`P2_MODE] == `MODE_NEXT || p2[`P2_MODE] == `MODE_PREV)) begin
                p1Eff = 8'h00;
            end
            wreg(`REG_P1, {24'h000000, p1Eff});
            wreg(`REG_P2, {24'h000000, p2});
            wreg(`REG_LEN, {24'h000000, ln});
            wreg(`REG_CMD, {30'h00000000, c});
            idle;
        end
    endtask
endmodule // terminal_model

// File: tb.sv
// self-checking bench for the file access engine
// assumes the terminal model drives the port and the checker is bound
`timescale 1ns/1ps
`include "file_access_map.vh"
module tb;
    localparam [1:0] TR = 2'h0, TW = 2'h1, RR = 2'h2, RU = 2'h3;
    reg          mclk;
    reg          rst_n;
    reg          rdSeen;
    wire [7:0]   addr;
    wire [31:0]  wdata;
    wire         wr;
    wire         rd;
    wire [31:0]  rdata;
    wire         busy;
    int          err_total;
    int          checks_done;
    int          i;
    reg  [31:0]  rnd;
    reg  [7:0]   mem [0:255];
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];

    file_access u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .busy(busy));
    terminal_model u_term (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    always #25 mclk = ~mclk;

    // read data stands one cycle only, so compare in that cycle
    always @(posedge mclk) begin
        rdSeen <= rd;
        if (rdSeen && expQ.size() != 0) begin
            checks_done = checks_done + 1;
            if ((rdata & mskQ[0]) !== (expQ[0] & mskQ[0])) begin
                err_total = err_total + 1;
                $display("Error %0t: read %h expected %h mask %h", $time, rdata, expQ[0], mskQ[0]);
            end
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
    end

    task expect_rd(input [7:0] a, input [31:0] ev, input [31:0] mv);
        begin
            expQ.push_back(ev);
            mskQ.push_back(mv);
            u_term.rreg(a);
        end
    endtask
    task cfg(input [31:0] idx, input [31:0] cw, input [31:0] gw);
        begin
            u_term.wreg(`REG_CFGSEL, idx);
            u_term.wreg(`REG_CFG, cw);
            u_term.wreg(`REG_GEOM, gw);
        end
    endtask
    // ptr of zero means no pointer set; a is the first store byte moved
    task run(input [1:0] c, input [7:0] p1, p2, ln, input [2:0] res, input [7:0] ptr, a);
        int k;
        begin
            u_term.issue(c, p1, p2, ln);
            expect_rd(`REG_STATUS, {8'h00, ptr, 9'h000, res, ptr != 8'h00, 2'h0, res == 3'h0 && ln != 8'h00},
                ptr != 8'h00 ? 32'h00FF0079 : 32'h00000079);
            for (k = 0; res == 3'h0 && k < ln; k++) begin
                rnd = $urandom;
                if (c[0]) begin
                    mem[a + k[7:0]] = rnd[7:0];
                    u_term.wreg(`REG_DATA, {24'h000000, rnd[7:0]});
                end else begin
                    expect_rd(`REG_DATA, {24'h000000, mem[a + k[7:0]]}, 32'h000000FF);
                end
            end
            u_term.idle;
        end
    endtask
    task test_done;
        int n;
        begin
            for (n = 0; n < 8 && expQ.size() != 0; n++) @(posedge mclk);
            if (expQ.size() != 0) err_total = err_total + 1;
            if (err_total == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_total = err_total + 1;
        test_done;
    end

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        rdSeen = 1'b0;
        err_total = 0;
        checks_done = 0;
        rnd = $urandom(32'h498D7CE6);
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        expect_rd(`REG_STATUS, 32'h00000000, 32'h00000379);
        u_term.wreg(8'h2C, 32'hFFFFFFFF);
        expect_rd(8'h2C, 32'h00000000, 32'hFFFFFFFF);
        expect_rd(`REG_DATA, 32'h00000000, 32'hFFFFFFFF);
        cfg(32'h0, 32'h1D, 32'h00040800);
        cfg(32'h1, 32'h2E, 32'h00030440);
        cfg(32'h2, 32'h3F, 32'h00030480);
        cfg(32'h3, 32'h41, 32'h000204C0);
        run(TW, 8'h00, 8'h18, 8'h08, 3'h0, 8'h00, 8'h18);
        run(TR, 8'h81, 8'h18, 8'h08, 3'h0, 8'h00, 8'h18);
        run(TR, 8'h00, 8'h19, 8'h08, 3'h5, 8'h00, 8'h00);
        run(TR, 8'h01, 8'h00, 8'h01, 3'h5, 8'h00, 8'h00);
        run(TR, 8'hA1, 8'h18, 8'h01, 3'h2, 8'h00, 8'h00);
        run(TR, 8'h84, 8'h00, 8'h01, 3'h1, 8'h00, 8'h00);
        run(TW, 8'h84, 8'h00, 8'h01, 3'h1, 8'h00, 8'h00);
        run(TR, 8'h85, 8'h00, 8'h01, 3'h3, 8'h00, 8'h00);
        run(RR, 8'h00, 8'h0C, 8'h04, 3'h4, 8'h00, 8'h00);
        run(TR, 8'h00, 8'h18, 8'h00, 3'h0, 8'h00, 8'h18);
        run(RR, 8'h00, 8'h14, 8'h04, 3'h5, 8'h00, 8'h00);
        run(RU, 8'h00, 8'h12, 8'h04, 3'h0, 8'h01, 8'h40);
        run(RU, 8'h00, 8'h02, 8'h04, 3'h0, 8'h02, 8'h44);
        run(RU, 8'h00, 8'h02, 8'h04, 3'h0, 8'h03, 8'h48);
        run(RU, 8'h00, 8'h02, 8'h04, 3'h5, 8'h03, 8'h00);
        run(RR, 8'h00, 8'h03, 8'h04, 3'h0, 8'h02, 8'h44);
        run(RR, 8'h03, 8'h04, 8'h04, 3'h0, 8'h02, 8'h48);
        run(RR, 8'h00, 8'h04, 8'h04, 3'h0, 8'h02, 8'h44);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h0, 8'h03, 8'h48);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h5, 8'h03, 8'h00);
        run(RR, 8'h04, 8'h04, 8'h04, 3'h5, 8'h03, 8'h00);
        run(RR, 8'h00, 8'h02, 8'h03, 3'h6, 8'h03, 8'h00);
        run(RR, 8'h00, 8'hFA, 8'h04, 3'h2, 8'h03, 8'h00);
        for (i = 0; i < 8; i++) begin
            if (i < 2 || i > 4) begin
                run(RR, 8'h00, i[7:0], 8'h04, 3'h2, 8'h03, 8'h00);
            end
        end
        run(RU, 8'h00, 8'h03, 8'h04, 3'h0, 8'h02, 8'h44);
        run(RU, 8'h00, 8'h03, 8'h04, 3'h0, 8'h01, 8'h40);
        run(RU, 8'h00, 8'h03, 8'h04, 3'h5, 8'h01, 8'h00);
        run(RU, 8'h02, 8'h04, 8'h04, 3'h0, 8'h01, 8'h44);
        run(RU, 8'h00, 8'h04, 8'h04, 3'h0, 8'h01, 8'h40);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h0, 8'h02, 8'h44);
        u_term.wreg(`REG_CFGSEL, 32'h1);
        u_term.wreg(`REG_CFG, 32'h22);
        run(RR, 8'h00, 8'h04, 8'h04, 3'h1, 8'h02, 8'h00);
        run(RU, 8'h00, 8'h02, 8'h04, 3'h1, 8'h02, 8'h00);
        u_term.wreg(`REG_CFG, 32'h2E);
        u_term.wreg(`REG_SELECT, 32'h1);
        run(RR, 8'h00, 8'h03, 8'h04, 3'h0, 8'h03, 8'h48);
        u_term.wreg(`REG_SELECT, 32'h1);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h0, 8'h01, 8'h40);
        run(RU, 8'h00, 8'h1B, 8'h04, 3'h0, 8'h01, 8'h88);
        run(RU, 8'h00, 8'h03, 8'h04, 3'h0, 8'h01, 8'h84);
        run(RU, 8'h00, 8'h03, 8'h04, 3'h0, 8'h01, 8'h80);
        run(RR, 8'h02, 8'h04, 8'h04, 3'h0, 8'h01, 8'h84);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h0, 8'h02, 8'h84);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h0, 8'h03, 8'h88);
        run(RR, 8'h00, 8'h02, 8'h04, 3'h0, 8'h01, 8'h80);
        run(RR, 8'h00, 8'h03, 8'h04, 3'h0, 8'h03, 8'h88);
        run(RU, 8'h00, 8'h03, 8'h04, 3'h0, 8'h01, 8'h88);
        run(RR, 8'h02, 8'h04, 8'h04, 3'h0, 8'h01, 8'h80);
        run(RU, 8'h01, 8'h04, 8'h04, 3'h4, 8'h01, 8'h00);
        run(RU, 8'h00, 8'h02, 8'h04, 3'h4, 8'h01, 8'h00);
        test_done;
    end
endmodule // tb
